// *** sit_pkg.sv ***
// Shared constants, types and helpers of the sensor bus target port
package sit_pkg;

	// Clock rate and derived timing
	localparam int CLK_MHZ            = 50;
	localparam int RELOAD_TIME_US     = 300;
	localparam int RELOAD_CYCLES      = RELOAD_TIME_US * CLK_MHZ;
	localparam int IDLE_HIGH_US       = 50;
	localparam int IDLE_HIGH_CYCLES   = IDLE_HIGH_US * CLK_MHZ;

	// Bus addresses and commands
	localparam logic [6:0] GEN_CALL_ADDR   = 7'h00;
	localparam logic [7:0] RELOAD_CMD      = 8'h04;
	localparam logic [6:0] TARGET_ADDR_RST = 7'h00;

	// Register map points
	localparam logic [5:0] PTR_RST         = 6'h00;
	localparam logic [5:0] ACC_CTRL_REG    = 6'h1F;
	localparam logic [5:0] TADDR_REG       = 6'h3F;
	localparam logic [5:0] WR_FIRST_REG    = 6'h14;
	localparam logic [5:0] WR_LAST_REG     = 6'h1D;
	localparam logic [5:0] EEP_ADDR_LOC    = 6'h00;

	// Access control values
	localparam logic [7:0] ACC_CTRL_RST    = 8'h00;
	localparam logic [7:0] ACC_CTRL_EEP_RD = 8'h80;

	// Stored address byte layout
	localparam int SAB_CTRL_BIT = 7;

	// Request towards the calibration memory
	typedef struct packed {
		logic       valid;
		logic [5:0] addr;
	} sit_eep_req_t;

	// Synchronised pin levels
	typedef struct packed {
		logic sel_high;
		logic sel_low;
		logic scl;
		logic sda;
	} sit_pins_t;

	// True for registers that the bus may write
	function automatic logic writable(input logic [5:0] idx);
		writable = ((idx >= WR_FIRST_REG) && (idx <= WR_LAST_REG)) || (idx == ACC_CTRL_REG);
	endfunction

	// Target address from stored byte and select pins
	function automatic logic [6:0] merge_addr(input logic [7:0] sab, input logic hi, input logic lo);
		merge_addr = sab[SAB_CTRL_BIT] ? {sab[6:2], hi, lo} : sab[6:0];
	endfunction

endpackage

// *** sit_sync.sv ***
// Two-stage synchroniser for pin levels
`timescale 1ns/1ns
module sit_sync #(
	parameter int          WIDTH     = 4,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			meta_q   <= RST_VAL;
			sync_out <= RST_VAL;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// *** sit_regfile.sv ***
// Byte-wide register memory with one write and two registered read ports
`timescale 1ns/1ns
module sit_regfile #(
	parameter int AW = 6,
	parameter int DW = 8
) (
	// Clock
	input  wire logic          clk_in,
	// Write port
	input  wire logic          wr_en_in,
	input  wire logic [AW-1:0] wr_addr_in,
	input  wire logic [DW-1:0] wr_data_in,
	// Bus read port
	input  wire logic [AW-1:0] rd_addr_in,
	output logic      [DW-1:0] rd_data_out,
	// User read port
	input  wire logic [AW-1:0] user_addr_in,
	output logic      [DW-1:0] user_data_out
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Write and registered reads
	always_ff @(posedge clk_in)
	begin
		if (wr_en_in)
			mem[wr_addr_in] <= wr_data_in;
		rd_data_out   <= mem[rd_addr_in];
		user_data_out <= mem[user_addr_in];
	end

endmodule

// *** sit_target_port.sv ***
// Serial bus target port with register pointer and address reload
// Notes on behaviour
// - Both lines are only ever pulled low through output enables.
// - Target only; acknowledge our own address and the general call, stay silent otherwise.
// - Start and stop conditions come from the controller and are detected here.
// - Busy after start; idle after stop or both lines high long enough.
// - Clock held low while the next byte is not ready.
// - Until an address is loaded only the general call is answered.
// - General call reload command loads the stored address byte from calibration memory.
// - Control flag set replaces two low bits with select pins high, low.
// - Default stored byte gives address 12 to 15 through the two select pins.
// - General call with command 0x04 then stop acknowledged and triggers reload.
// - Reload finishes within 300 microseconds or is abandoned.
// - First byte written after our own address is the register pointer.
// - Read stretches the clock after the address byte until data loaded.
// - Pointer increments after every read byte; clock may stretch again.
// - Read pointer wraps to zero past 63.
// - Stop, repeated start or not-acknowledge ends a read; data released.
// - Each written byte is stored if its register is writable; the pointer increments either way.
// - Write pointer wraps past 63.
// - Write ended at any byte keeps only the completed bytes.
// - Bus writes to non-writable registers are dropped.
// - In calibration read mode the pointer addresses calibration memory.
`timescale 1ns/1ns
module sit_target_port #(
	parameter int RELOAD_CYCLES    = sit_pkg::RELOAD_CYCLES,
	parameter int IDLE_HIGH_CYCLES = sit_pkg::IDLE_HIGH_CYCLES
) (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	// Serial clock line
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe_out,
	// Serial data line
	input  wire logic       serial_data_line_in,
	output logic            serial_data_line_out,
	output logic            serial_data_line_oe_out,
	// Address select pins
	input  wire logic       address_select_high_pin_in,
	input  wire logic       address_select_low_pin_in,
	// Calibration memory port
	output logic            eeprom_req_out,
	output logic [5:0]      eeprom_addr_out,
	input  wire logic [7:0] eeprom_data_in,
	input  wire logic       eeprom_ack_in,
	// User side register access
	input  wire logic       user_wr_en_in,
	input  wire logic [5:0] user_wr_addr_in,
	input  wire logic [7:0] user_wr_data_in,
	output logic            user_wr_ready_out,
	input  wire logic [5:0] user_rd_addr_in,
	output logic [7:0]      user_rd_data_out,
	// Status
	output logic [6:0]      target_address_out,
	output logic            address_loaded_out,
	output logic            bus_busy_out,
	output logic            reload_busy_out,
	output logic [7:0]      eeprom_access_control_out
);

	typedef enum logic [6:0] {
		ST_IDLE  = 7'b0000001,
		ST_ADDR  = 7'b0000010,
		ST_ACK   = 7'b0000100,
		ST_RX    = 7'b0001000,
		ST_FETCH = 7'b0010000,
		ST_TX    = 7'b0100000,
		ST_RACK  = 7'b1000000
	} sit_state_t;

	sit_state_t           state_q;
	sit_pkg::sit_pins_t   pins_s;
	sit_pkg::sit_eep_req_t eep_q;
	logic       scl_p_q, sda_p_q;
	logic [7:0] shreg_q;
	logic [2:0] bit_cnt_q;
	logic       got_q, next_rd_q, is_gc_q, first_q, mack_q, issued_q, eep_for_reload_q;
	logic [5:0] ptr_q;
	logic [7:0] acc_ctrl_q;
	logic [6:0] taddr_q;
	logic       loaded_q, busy_q, reload_pend_q, reload_busy_q, reload_sent_q;
	logic [31:0] reload_cnt_q, idle_cnt_q;
	logic       sda_oe_q, scl_oe_q, stretch_tail_q;
	logic [7:0] mem_rdata;

	logic scl_rise, scl_fall, start_det, stop_det;
	logic match_gc, match_own, addr_end, rx_end, eep_mode, data_ok, bus_wr;
	logic [7:0] fetch_data;

	// Pin synchronisers
	sit_sync #(
		.WIDTH   (4),
		.RST_VAL (4'hF)
	) u_sync (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.async_in ({address_select_high_pin_in, address_select_low_pin_in, scl_in, serial_data_line_in}),
		.sync_out (pins_s)
	);

	// Register storage
	sit_regfile #(
		.AW (6),
		.DW (8)
	) u_regs (
		.clk_in        (clk_in),
		.wr_en_in      (bus_wr | user_wr_en_in),
		.wr_addr_in    (bus_wr ? ptr_q : user_wr_addr_in),
		.wr_data_in    (bus_wr ? shreg_q : user_wr_data_in),
		.rd_addr_in    (ptr_q),
		.rd_data_out   (mem_rdata),
		.user_addr_in  (user_rd_addr_in),
		.user_data_out (user_rd_data_out)
	);

	// Previous line levels for edge finding
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_p_q <= pins_s.scl;
			sda_p_q <= pins_s.sda;
		end
	end

	// Edges and bus conditions
	assign scl_rise  = pins_s.scl & ~scl_p_q;
	assign scl_fall  = ~pins_s.scl & scl_p_q;
	assign start_det = pins_s.scl & scl_p_q & sda_p_q & ~pins_s.sda;
	assign stop_det  = pins_s.scl & scl_p_q & ~sda_p_q & pins_s.sda;

	// Address match and byte boundaries
	assign match_gc  = (shreg_q[7:1] == sit_pkg::GEN_CALL_ADDR) & ~shreg_q[0];
	assign match_own = loaded_q & (shreg_q[7:1] == taddr_q);
	assign addr_end  = (state_q == ST_ADDR) & scl_fall & got_q;
	assign rx_end    = (state_q == ST_RX) & scl_fall & got_q;
	assign eep_mode  = (acc_ctrl_q == sit_pkg::ACC_CTRL_EEP_RD);
	assign bus_wr    = rx_end & ~is_gc_q & ~first_q & sit_pkg::writable(ptr_q);
	assign user_wr_ready_out = ~bus_wr;

	// Fetched byte is ready to be shifted out
	assign data_ok = (state_q == ST_FETCH) & issued_q &
		(eep_mode ? (eeprom_ack_in & eep_q.valid & ~eep_for_reload_q) : 1'b1);
	assign fetch_data = eep_mode ? eeprom_data_in :
		((ptr_q == sit_pkg::TADDR_REG) ? {1'b0, taddr_q} : mem_rdata);

	// Byte level sequencer
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			state_q   <= ST_IDLE;
			shreg_q   <= 8'h00;
			bit_cnt_q <= 3'h0;
			got_q     <= 1'b0;
			next_rd_q <= 1'b0;
			is_gc_q   <= 1'b0;
			first_q   <= 1'b0;
			mack_q    <= 1'b0;
		end
		else if (stop_det)
			state_q <= ST_IDLE;
		else if (start_det)
		begin
			state_q   <= ST_ADDR;
			bit_cnt_q <= 3'h0;
			got_q     <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE: ;
				ST_ADDR, ST_RX:
				begin
					if (scl_rise && !got_q)
					begin
						shreg_q   <= {shreg_q[6:0], pins_s.sda};
						bit_cnt_q <= bit_cnt_q + 3'h1;
						got_q     <= (bit_cnt_q == 3'h7);
					end
					if (addr_end)
					begin
						if (match_gc || match_own)
						begin
							state_q   <= ST_ACK;
							next_rd_q <= match_own & shreg_q[0];
							is_gc_q   <= match_gc;
							first_q   <= 1'b1;
						end
						else
							state_q <= ST_IDLE;
					end
					if (rx_end)
					begin
						state_q   <= ST_ACK;
						next_rd_q <= 1'b0;
						first_q   <= 1'b0;
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						state_q   <= next_rd_q ? ST_FETCH : ST_RX;
						bit_cnt_q <= 3'h0;
						got_q     <= 1'b0;
					end
				end
				ST_FETCH:
				begin
					if (data_ok)
					begin
						shreg_q   <= fetch_data;
						bit_cnt_q <= 3'h0;
						state_q   <= ST_TX;
					end
				end
				ST_TX:
				begin
					if (scl_fall)
					begin
						if (bit_cnt_q == 3'h7)
							state_q <= ST_RACK;
						else
						begin
							shreg_q   <= {shreg_q[6:0], 1'b0};
							bit_cnt_q <= bit_cnt_q + 3'h1;
						end
					end
				end
				ST_RACK:
				begin
					if (scl_rise)
						mack_q <= ~pins_s.sda;
					if (scl_fall)
						state_q <= mack_q ? ST_FETCH : ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Register pointer
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			ptr_q <= sit_pkg::PTR_RST;
		else if (rx_end && !is_gc_q)
			ptr_q <= first_q ? shreg_q[5:0] : ptr_q + 6'h01;
		else if (data_ok)
			ptr_q <= ptr_q + 6'h01;
	end

	// Access control register
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			acc_ctrl_q <= sit_pkg::ACC_CTRL_RST;
		else if (bus_wr && ptr_q == sit_pkg::ACC_CTRL_REG)
			acc_ctrl_q <= shreg_q;
	end

	// Fetch issue tracking
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			issued_q <= 1'b0;
		else if (state_q != ST_FETCH || data_ok)
			issued_q <= 1'b0;
		else if (!eep_mode)
			issued_q <= 1'b1;   // Registered read lands one cycle later
		else if (!eep_q.valid && !reload_busy_q)
			issued_q <= 1'b1;
	end

	// Calibration memory request port
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			eep_q            <= '0;
			eep_for_reload_q <= 1'b0;
		end
		else if (eep_q.valid)
		begin
			if (eeprom_ack_in)
				eep_q.valid <= 1'b0;
		end
		else if (reload_busy_q && !reload_sent_q)
		begin
			eep_q            <= '{valid: 1'b1, addr: sit_pkg::EEP_ADDR_LOC};
			eep_for_reload_q <= 1'b1;
		end
		else if (state_q == ST_FETCH && eep_mode && !issued_q && !reload_busy_q)
		begin
			eep_q            <= '{valid: 1'b1, addr: ptr_q};
			eep_for_reload_q <= 1'b0;
		end
	end

	assign eeprom_req_out  = eep_q.valid;
	assign eeprom_addr_out = eep_q.addr;

	// Address reload after general call command
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			reload_pend_q <= 1'b0;
			reload_busy_q <= 1'b0;
			reload_sent_q <= 1'b0;
			reload_cnt_q  <= 32'h0;
		end
		else
		begin
			if (start_det)
				reload_pend_q <= 1'b0;
			else if (rx_end && is_gc_q && first_q && shreg_q == sit_pkg::RELOAD_CMD)
				reload_pend_q <= 1'b1;
			else if (stop_det && reload_pend_q)
			begin
				reload_pend_q <= 1'b0;
				reload_busy_q <= 1'b1;
				reload_sent_q <= 1'b0;
				reload_cnt_q  <= 32'h0;
			end
			if (reload_busy_q)
			begin
				reload_cnt_q <= reload_cnt_q + 32'h1;
				if (!eep_q.valid && !reload_sent_q)
					reload_sent_q <= 1'b1;
				if ((eep_q.valid && eep_for_reload_q && eeprom_ack_in) ||
					reload_cnt_q >= 32'(RELOAD_CYCLES - 1))
					reload_busy_q <= 1'b0;
			end
		end
	end

	// Target address register
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			taddr_q  <= sit_pkg::TARGET_ADDR_RST;
			loaded_q <= 1'b0;
		end
		else if (reload_busy_q && eep_q.valid && eep_for_reload_q && eeprom_ack_in)
		begin
			taddr_q  <= sit_pkg::merge_addr(eeprom_data_in, pins_s.sel_high, pins_s.sel_low);
			loaded_q <= 1'b1;
		end
	end

	// Bus busy tracking
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			busy_q     <= 1'b0;
			idle_cnt_q <= 32'h0;
		end
		else
		begin
			idle_cnt_q <= (pins_s.scl && pins_s.sda) ? idle_cnt_q + 32'h1 : 32'h0;
			if (start_det)
				busy_q <= 1'b1;
			else if (stop_det || idle_cnt_q >= 32'(IDLE_HIGH_CYCLES))
				busy_q <= 1'b0;
		end
	end

	// Open-drain line drivers
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			sda_oe_q       <= 1'b0;
			scl_oe_q       <= 1'b0;
			stretch_tail_q <= 1'b0;
		end
		else
		begin
			sda_oe_q       <= (state_q == ST_ACK) | ((state_q == ST_TX) & ~shreg_q[7]);
			stretch_tail_q <= (state_q == ST_FETCH);
			scl_oe_q       <= (state_q == ST_FETCH) | stretch_tail_q;
		end
	end

	assign scl_out                 = 1'b0;
	assign scl_oe_out              = scl_oe_q;
	assign serial_data_line_out    = 1'b0;
	assign serial_data_line_oe_out = sda_oe_q;

	// Status outputs
	assign target_address_out        = taddr_q;
	assign address_loaded_out        = loaded_q;
	assign bus_busy_out              = busy_q;
	assign reload_busy_out           = reload_busy_q;
	assign eeprom_access_control_out = acc_ctrl_q;

endmodule

// *** sit_target_port_props.sv ***
// Concurrent checks on the pins of the sensor bus target port
`timescale 1ns/1ns
module sit_target_port_props #(
	parameter int RELOAD_CYCLES    = sit_pkg::RELOAD_CYCLES,
	parameter int IDLE_HIGH_CYCLES = sit_pkg::IDLE_HIGH_CYCLES
) (
	// Clock and reset
	input wire logic       clk_in,
	input wire logic       reset_in,
	// Bus pins
	input wire logic       scl_in,
	input wire logic       scl_out,
	input wire logic       scl_oe_out,
	input wire logic       serial_data_line_in,
	input wire logic       serial_data_line_out,
	input wire logic       serial_data_line_oe_out,
	input wire logic       address_select_high_pin_in,
	input wire logic       address_select_low_pin_in,
	// Calibration memory
	input wire logic       eeprom_req_out,
	input wire logic [5:0] eeprom_addr_out,
	input wire logic [7:0] eeprom_data_in,
	input wire logic       eeprom_ack_in,
	// Status
	input wire logic       user_wr_ready_out,
	input wire logic [6:0] target_address_out,
	input wire logic       address_loaded_out,
	input wire logic       bus_busy_out,
	input wire logic       reload_busy_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);

	// Stored byte seen one cycle back
	logic [7:0] sab_q;
	always_ff @(posedge clk_in)
		sab_q <= eeprom_data_in;

	// Line and reset behaviour
	drive_low_a: assert property (!scl_out && !serial_data_line_out)
		else $error("bus line driven high");
	reset_clear_a: assert property ($fell(reset_in) |-> !address_loaded_out && target_address_out == 7'h00)
		else $error("address not cleared");
	loaded_keep_a: assert property (address_loaded_out |=> address_loaded_out)
		else $error("loaded flag dropped");
	start_busy_a: assert property (scl_in && $fell(serial_data_line_in) |-> ##[1:6] bus_busy_out)
		else $error("start not seen");
	idle_quiet_a: assert property (!bus_busy_out && !$past(bus_busy_out) |-> !serial_data_line_oe_out && !scl_oe_out)
		else $error("line held while idle");

	// Reload through calibration memory and user write port gap
	req_hold_a: assert property (eeprom_req_out && !eeprom_ack_in |=> eeprom_req_out && $stable(eeprom_addr_out))
		else $error("memory request unstable");
	req_drop_a: assert property (eeprom_req_out && eeprom_ack_in |=> !eeprom_req_out)
		else $error("memory request kept");
	reload_fetch_a: assert property ($rose(reload_busy_out) |-> ##[0:3] eeprom_req_out && eeprom_addr_out == 6'h00)
		else $error("reload fetch missing");
	addr_merge_a: assert property (eeprom_ack_in && eeprom_req_out && reload_busy_out |=> target_address_out ==
		(sab_q[7] ? {sab_q[6:2], address_select_high_pin_in, address_select_low_pin_in} : sab_q[6:0]))
		else $error("wrong merged address");
	wr_gap_a: assert property (!user_wr_ready_out |=> user_wr_ready_out)
		else $error("user port blocked too long");

	// Main scenarios reached
	cover property ($rose(address_loaded_out));
	cover property ($rose(scl_oe_out));
	cover property (eeprom_ack_in && !reload_busy_out);
endmodule

// *** sit_ctrl_model.sv ***
// Bus controller model pulling clock and data low through open drains
`timescale 1ns/1ns
module sit_ctrl_model (
	// Clock
	input  wire logic clk_in,
	// Wired bus levels
	input  wire logic scl_in,
	input  wire logic sda_in,
	// Pull-down enables
	output logic      scl_oe_out,
	output logic      sda_oe_out
);
	// Both lines released at start
	initial
	begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
	end

	// Half a bus clock period
	task automatic hp;
		repeat (3) @(negedge clk_in);
	endtask

	// Release clock and wait out any stretch
	task automatic scl_up;
		int n;
		scl_oe_out = 1'b0;
		n = 0;
		@(negedge clk_in);
		while (!scl_in && n < 20000)
		begin
			@(negedge clk_in);
			n++;
		end
		hp();
	endtask

	// Start or repeated start
	task automatic start;
		sda_oe_out = 1'b0;
		hp();
		scl_up();
		sda_oe_out = 1'b1;
		hp();
		scl_oe_out = 1'b1;
		@(negedge clk_in);
	endtask

	// Stop
	task automatic stop;
		sda_oe_out = 1'b1;
		hp();
		scl_up();
		sda_oe_out = 1'b0;
		hp();
	endtask

	// One bit, sampled at the end of the high phase
	task automatic bit_x(input logic b, output logic r);
		sda_oe_out = !b;
		hp();
		scl_up();
		r = sda_in;
		scl_oe_out = 1'b1;
		@(negedge clk_in);
	endtask

	// Byte out, most significant bit first, then the ack slot
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask

	// Byte in; last byte answered with not-acknowledge
	task automatic rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(last, r);
	endtask
endmodule

// *** sit_target_port_tb_top.sv ***
// Self-checking bench for the sensor bus target port
`timescale 1ns/1ns
module sit_target_port_tb_top;
	// Stimulus and observed signals
	logic       clk_in, reset_in, m_scl, m_sda, sel_hi, sel_lo, e_ack, u_we, ak;
	logic       scl_oe, sda_oe, e_req, u_rdy, loaded, busy, rl_busy;
	logic [5:0] e_addr, u_wa, u_ra;
	logic [6:0] ta;
	logic [7:0] e_data, u_wd, u_rd, acc_ctrl, q [$];
	logic [7:0] eep [64];
	int         num_errors, samples_checked, e_lat, e_cnt;
	wire        scl = !(m_scl || scl_oe);
	wire        sda = !(m_sda || sda_oe);

	sit_target_port #(.RELOAD_CYCLES(200), .IDLE_HIGH_CYCLES(100)) DUT (
		.clk_in, .reset_in, .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe),
		.serial_data_line_in(sda), .serial_data_line_out(), .serial_data_line_oe_out(sda_oe),
		.address_select_high_pin_in(sel_hi), .address_select_low_pin_in(sel_lo),
		.eeprom_req_out(e_req), .eeprom_addr_out(e_addr), .eeprom_data_in(e_data), .eeprom_ack_in(e_ack),
		.user_wr_en_in(u_we), .user_wr_addr_in(u_wa), .user_wr_data_in(u_wd), .user_wr_ready_out(u_rdy),
		.user_rd_addr_in(u_ra), .user_rd_data_out(u_rd), .target_address_out(ta),
		.address_loaded_out(loaded), .bus_busy_out(busy), .reload_busy_out(rl_busy),
		.eeprom_access_control_out(acc_ctrl)
	);
	sit_ctrl_model m (.clk_in, .scl_in(scl), .sda_in(sda), .scl_oe_out(m_scl), .sda_oe_out(m_sda));

	// Clock of 20 ns
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	// Calibration memory answering after a settable delay
	always @(negedge clk_in)
	begin
		e_ack <= 1'b0;
		e_data <= ~e_data;
		if (e_req && !e_ack)
		begin
			e_cnt <= e_cnt + 1;
			if (e_cnt >= e_lat)
			begin
				e_ack <= 1'b1;
				e_data <= eep[e_addr];
				e_cnt <= 0;
			end
		end
	end

	task automatic end_sim;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string s);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %0t %s got %h want %h", $time, s, g, e);
		end
	endtask

	task automatic uwr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk_in);
		{u_wa, u_wd, u_we} = {a, d, 1'b1};
		@(negedge clk_in);
		u_we = 1'b0;
	endtask

	task automatic ucheck(input logic [5:0] a, input logic [7:0] e);
		u_ra = a;
		repeat (2) @(negedge clk_in);
		chk(u_rd, e, "register content");
	endtask

	task automatic xfer_w(input logic [6:0] a, input logic [7:0] b [$]);
		m.start();
		m.wr({a, 1'b0}, ak);
		chk({7'h00, ak}, 8'h01, "address ack");
		foreach (b[i])
		begin
			m.wr(b[i], ak);
			chk({7'h00, ak}, 8'h01, "byte ack");
		end
		m.stop();
	endtask

	task automatic xfer_r(input logic [6:0] a, input logic [7:0] p, input int n, output logic [7:0] r [$]);
		logic [7:0] d;
		r = {};
		m.start();
		m.wr({a, 1'b0}, ak);
		m.wr(p, ak);
		m.start();
		m.wr({a, 1'b1}, ak);
		chk({7'h00, ak}, 8'h01, "read address ack");
		for (int i = 0; i < n; i++)
		begin
			m.rd(i == n - 1, d);
			r.push_back(d);
		end
		m.stop();
	endtask

	task automatic reload;
		int n;
		xfer_w(7'h00, '{sit_pkg::RELOAD_CMD});
		repeat (6) @(negedge clk_in);
		n = 0;
		while (rl_busy && n < 400)
		begin
			@(negedge clk_in);
			n++;
		end
		chk({6'h00, rl_busy, loaded}, 8'h01, "reload");
	endtask

	// Hang guard
	initial
	begin
		#1500000;
		num_errors++;
		end_sim();
	end

	// Main sequence
	initial
	begin
		{reset_in, sel_hi, sel_lo, u_we, u_wa, u_wd, u_ra} = {3'b101, 21'h0};
		{e_lat, e_cnt, e_ack, e_data} = {32'd2, 32'd0, 9'h0};
		foreach (eep[i])
			eep[i] = 8'hC3 ^ 8'(i);
		eep[0] = 8'h8C;
		repeat (10) @(negedge clk_in);
		reset_in = 1'b0;
		repeat (4) @(negedge clk_in);
		chk({loaded, ta}, 8'h00, "reset state");
		m.start();
		m.wr(8'h18, ak);
		m.stop();
		chk({7'h00, ak}, 8'h00, "early ack");
		reload();
		chk({1'b0, ta}, 8'h0D, "merged address");
		uwr(6'h1E, 8'h77);
		uwr(6'h15, 8'h66);
		xfer_w(7'h0D, '{8'h5C, 8'h11, 8'h22, 8'h33});
		ucheck(6'h1C, 8'h11);
		ucheck(6'h1D, 8'h22);
		ucheck(6'h1E, 8'h77);
		m.start();
		m.wr({7'h0D, 1'b0}, ak);
		m.wr(8'h14, ak);
		m.wr(8'hA5, ak);
		repeat (4) m.bit_x(1'b0, ak);
		m.stop();
		ucheck(6'h14, 8'hA5);
		ucheck(6'h15, 8'h66);
		uwr(6'h3E, 8'h5C);
		uwr(6'h00, 8'h3C);
		xfer_r(7'h0D, 8'h3E, 3, q);
		chk(q[0], 8'h5C, "read byte");
		chk(q[1], 8'h0D, "address register");
		chk(q[2], 8'h3C, "read wrap");
		repeat (4) @(negedge clk_in);
		chk({6'h00, busy, sda_oe}, 8'h00, "bus not released");
		e_lat = 20;
		xfer_w(7'h0D, '{8'h1F, sit_pkg::ACC_CTRL_EEP_RD});
		chk(acc_ctrl, sit_pkg::ACC_CTRL_EEP_RD, "access mode");
		xfer_r(7'h0D, 8'h3F, 2, q);
		chk(q[0], eep[63], "calibration read");
		chk(q[1], eep[0], "calibration wrap");
		xfer_w(7'h0D, '{8'h1F, 8'h00});
		chk(acc_ctrl, 8'h00, "access clear");
		eep[0] = 8'h0C;
		sel_hi = 1'b1;
		reload();
		chk({1'b0, ta}, 8'h0C, "stored address");
		m.start();
		m.wr({7'h0D, 1'b0}, ak);
		m.stop();
		chk({7'h00, ak}, 8'h00, "foreign ack");
		end_sim();
	end
endmodule

bind sit_target_port sit_target_port_props #(
	.RELOAD_CYCLES    (RELOAD_CYCLES),
	.IDLE_HIGH_CYCLES (IDLE_HIGH_CYCLES)
) u_props (
	.clk_in, .reset_in, .scl_in, .scl_out, .scl_oe_out, .serial_data_line_in, .serial_data_line_out,
	.serial_data_line_oe_out, .address_select_high_pin_in, .address_select_low_pin_in, .eeprom_req_out,
	.eeprom_addr_out, .eeprom_data_in, .eeprom_ack_in, .user_wr_ready_out, .target_address_out,
	.address_loaded_out, .bus_busy_out, .reload_busy_out
);
